// ---- core/acr_config_regs.sv ----
// Configuration registers for reference, rejection filter, excitation sources and ready signalling.
`timescale 1ns/1ns
`default_nettype none
module acr_config_regs (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rdata_valid_o,
  input wire logic [1:0] op_mode_i,
  input wire logic [2:0] rate_code_i,
  input wire logic converting_i,
  input wire logic data_avail_i,
  input wire logic shift_active_i,
  input wire logic shift_bit_i,
  input wire logic chip_select_n_i,
  output logic internal_ref_en_o,
  output logic dedicated_ref_en_o,
  output logic shared_ref_en_o,
  output logic supply_ref_en_o,
  output logic reject_50_o,
  output logic reject_60_o,
  output logic low_side_switch_enable_o,
  output logic [2:0] excitation_magnitude_o,
  output logic [10:0] excitation_current_ua_o,
  output logic [5:0] first_excitation_source_o,
  output logic [5:0] second_excitation_source_o,
  output logic shared_output_ready_pin_o,
  output logic shared_output_ready_pin_oe_o,
  output logic dedicated_ready_pin_n_o
);
  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  // Code 111 routes nowhere so an unused setting can never connect a source to a pin.
  function automatic logic [5:0] route_onehot(input logic [2:0] code);
    logic [5:0] r;
    r = 6'h00;
    case (code)
      3'h1: r = 6'h01;
      3'h2: r = 6'h02;
      3'h3: r = 6'h04;
      3'h4: r = 6'h08;
      3'h5: r = 6'h10;
      3'h6: r = 6'h20;
      default: r = 6'h00;
    endcase
    return r;
  endfunction

  function automatic logic [10:0] current_ua(input logic [2:0] code);
    logic [10:0] c;
    c = acr_pkg::UA_OFF;
    case (code)
      3'h1: c = acr_pkg::UA_10;
      3'h2: c = acr_pkg::UA_50;
      3'h3: c = acr_pkg::UA_100;
      3'h4: c = acr_pkg::UA_250;
      3'h5: c = acr_pkg::UA_500;
      3'h6: c = acr_pkg::UA_1000;
      3'h7: c = acr_pkg::UA_1500;
      default: c = acr_pkg::UA_OFF;
    endcase
    return c;
  endfunction

  // Only the two implemented offsets take a write; strobes to any other index fall away.
  function automatic logic write_hit(input logic wr, input logic [1:0] addr, input logic [1:0] ofs);
    return wr && (addr == ofs);
  endfunction

  // ----------------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------------
  logic [7:0] reference_filter_excitation_config;
  logic [7:0] excitation_routing_ready_config;
  logic [7:0] next_ref_cfg;
  logic [7:0] next_route_cfg;
  logic [7:0] next_rdata;
  logic next_rvalid;
  always_comb begin
    next_ref_cfg = reference_filter_excitation_config;
    next_route_cfg = excitation_routing_ready_config;
    next_rdata = reg_rdata_o;
    next_rvalid = 1'b0;
    if (write_hit(reg_wr_i, reg_addr_i, acr_pkg::REF_FILT_EXC_OFS)) begin
      next_ref_cfg = reg_wdata_i;
    end
    if (write_hit(reg_wr_i, reg_addr_i, acr_pkg::ROUTE_READY_OFS)) begin
      next_route_cfg = reg_wdata_i;
      // A stray one in the reserved bit is dropped so it can never read back.
      next_route_cfg[acr_pkg::RESERVED_BIT] = 1'b0;
    end
    // A read in the same cycle as a write to that offset returns the old contents.
    if (reg_rd_i) begin
      next_rvalid = 1'b1;
      case (reg_addr_i)
        acr_pkg::REF_FILT_EXC_OFS: next_rdata = reference_filter_excitation_config;
        acr_pkg::ROUTE_READY_OFS: next_rdata = excitation_routing_ready_config;
        default: next_rdata = 8'h00;
      endcase
    end
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reference_filter_excitation_config <= acr_pkg::REF_FILT_EXC_RST;
      excitation_routing_ready_config <= acr_pkg::ROUTE_READY_RST;
      reg_rdata_o <= 8'h00;
      reg_rdata_valid_o <= 1'b0;
    end else begin
      reference_filter_excitation_config <= next_ref_cfg;
      excitation_routing_ready_config <= next_route_cfg;
      reg_rdata_o <= next_rdata;
      reg_rdata_valid_o <= next_rvalid;
    end
  end

  // ----------------------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------------------
  logic [1:0] ref_sel;
  logic [1:0] filt_sel;
  logic [2:0] mag_sel;
  logic [2:0] first_route;
  logic [2:0] second_route;
  logic filter_applies;
  always_comb begin
    ref_sel = reference_filter_excitation_config[acr_pkg::REF_SEL_LSB +: 2];
    filt_sel = reference_filter_excitation_config[acr_pkg::FILT_LSB +: 2];
    mag_sel = reference_filter_excitation_config[acr_pkg::MAG_LSB +: 3];
    first_route = excitation_routing_ready_config[acr_pkg::FIRST_ROUTE_LSB +: 3];
    second_route = excitation_routing_ready_config[acr_pkg::SECOND_ROUTE_LSB +: 3];
    // Turbo mode and every faster rate leave both rejection outputs cleared, whatever the field holds.
    filter_applies = (rate_code_i == acr_pkg::RATE_SLOWEST) &&
                     (op_mode_i == acr_pkg::MODE_NORMAL || op_mode_i == acr_pkg::MODE_DUTY);
  end

  // ----------------------------------------------------------------------------
  // Registered analog controls
  // ----------------------------------------------------------------------------
  logic [3:0] next_ref_en;
  logic [1:0] next_reject;
  logic next_switch;
  logic [10:0] next_current;
  logic [5:0] next_first;
  logic [5:0] next_second;
  always_comb begin
    next_ref_en = 4'h0;
    case (ref_sel)
      acr_pkg::REF_INTERNAL: next_ref_en = 4'h1;
      acr_pkg::REF_DEDICATED: next_ref_en = 4'h2;
      acr_pkg::REF_SHARED: next_ref_en = 4'h4;
      acr_pkg::REF_SUPPLY: next_ref_en = 4'h8;
      default: next_ref_en = 4'h1;
    endcase
    next_reject = 2'h0;
    if (filter_applies) begin
      case (filt_sel)
        acr_pkg::FILT_NONE: next_reject = 2'h0;
        acr_pkg::FILT_BOTH: next_reject = 2'h3;
        acr_pkg::FILT_50: next_reject = 2'h1;
        acr_pkg::FILT_60: next_reject = 2'h2;
        default: next_reject = 2'h0;
      endcase
    end
    // Power-down is read from the converter state, so the switch opens without software.
    next_switch = reference_filter_excitation_config[acr_pkg::SWITCH_BIT] & converting_i;
    next_current = current_ua(mag_sel);
    next_first = route_onehot(first_route);
    next_second = route_onehot(second_route);
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      internal_ref_en_o <= 1'b1;
      dedicated_ref_en_o <= 1'b0;
      shared_ref_en_o <= 1'b0;
      supply_ref_en_o <= 1'b0;
      reject_50_o <= 1'b0;
      reject_60_o <= 1'b0;
      low_side_switch_enable_o <= 1'b0;
      excitation_magnitude_o <= 3'h0;
      excitation_current_ua_o <= acr_pkg::UA_OFF;
      first_excitation_source_o <= 6'h00;
      second_excitation_source_o <= 6'h00;
    end else begin
      internal_ref_en_o <= next_ref_en[0];
      dedicated_ref_en_o <= next_ref_en[1];
      shared_ref_en_o <= next_ref_en[2];
      supply_ref_en_o <= next_ref_en[3];
      reject_50_o <= next_reject[0];
      reject_60_o <= next_reject[1];
      low_side_switch_enable_o <= next_switch;
      excitation_magnitude_o <= mag_sel;
      excitation_current_ua_o <= next_current;
      first_excitation_source_o <= next_first;
      second_excitation_source_o <= next_second;
    end
  end

  // ----------------------------------------------------------------------------
  // Ready signalling
  // ----------------------------------------------------------------------------
  acr_ready_if rdy ();
  assign rdy.ready_signal_mode = excitation_routing_ready_config[acr_pkg::READY_MODE_BIT];
  assign rdy.data_avail = data_avail_i;
  assign rdy.shift_active = shift_active_i;
  assign rdy.shift_bit = shift_bit_i;

  // Chip select crosses in from the pin through two flops, so the shared pin answers three clocks after it moves.
  acr_pin_driver u_pin_driver (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .chip_select_n_i(chip_select_n_i),
    .rdy(rdy.drv),
    .shared_output_ready_pin_o(shared_output_ready_pin_o),
    .shared_output_ready_pin_oe_o(shared_output_ready_pin_oe_o),
    .dedicated_ready_pin_n_o(dedicated_ready_pin_n_o)
  );
endmodule
`default_nettype wire

// ---- core/acr_pin_driver.sv ----
// Driver for the dedicated ready pin and the shared data-output/ready pin.
`timescale 1ns/1ns
`default_nettype none
module acr_pin_driver (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic chip_select_n_i,
  acr_ready_if.drv rdy,
  output logic shared_output_ready_pin_o,
  output logic shared_output_ready_pin_oe_o,
  output logic dedicated_ready_pin_n_o
);
  // ----------------------------------------------------------------------------
  // Chip select synchroniser
  // ----------------------------------------------------------------------------
  logic cs_meta;
  logic cs_sync;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
    end else begin
      cs_meta <= chip_select_n_i;
      cs_sync <= cs_meta;
    end
  end
  // ----------------------------------------------------------------------------
  // Pin state
  // ----------------------------------------------------------------------------
  acr_pkg::acr_pin_e state;
  acr_pkg::acr_pin_e next_state;
  logic next_out;
  logic next_oe;
  logic next_ready_n;
  always_comb begin
    next_state = state;
    next_out = 1'b1;
    next_oe = 1'b0;
    next_ready_n = ~rdy.data_avail;
    case (state)
      acr_pkg::PIN_IDLE: begin
        if (!cs_sync) begin
          next_state = rdy.ready_signal_mode ? acr_pkg::PIN_STATUS : acr_pkg::PIN_DATA;
        end
      end
      acr_pkg::PIN_STATUS: begin
        if (rdy.shift_active) begin
          next_state = acr_pkg::PIN_DATA;
        end
      end
      acr_pkg::PIN_DATA: begin
      end
      default: begin
        next_state = acr_pkg::PIN_IDLE;
      end
    endcase
    if (cs_sync) begin
      next_state = acr_pkg::PIN_IDLE;
    end
    if (next_state == acr_pkg::PIN_STATUS) begin
      next_out = ~rdy.data_avail;
      next_oe = 1'b1;
    end else if (next_state == acr_pkg::PIN_DATA) begin
      next_out = rdy.shift_bit;
      next_oe = 1'b1;
    end
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= acr_pkg::PIN_IDLE;
      shared_output_ready_pin_o <= 1'b1;
      shared_output_ready_pin_oe_o <= 1'b0;
      dedicated_ready_pin_n_o <= 1'b1;
    end else begin
      state <= next_state;
      shared_output_ready_pin_o <= next_out;
      shared_output_ready_pin_oe_o <= next_oe;
      dedicated_ready_pin_n_o <= next_ready_n;
    end
  end
endmodule
`default_nettype wire

// ---- core/acr_pkg.sv ----
// Constants shared by the reference, filter and excitation configuration registers.
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package acr_pkg;
  // ----------------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------------
  localparam logic [1:0] REF_FILT_EXC_OFS = 2'h2;
  localparam logic [1:0] ROUTE_READY_OFS = 2'h3;
  localparam logic [7:0] REF_FILT_EXC_RST = 8'h00;
  localparam logic [7:0] ROUTE_READY_RST = 8'h00;
  // Field positions.
  localparam int REF_SEL_LSB = 6;
  localparam int FILT_LSB = 4;
  localparam int SWITCH_BIT = 3;
  localparam int MAG_LSB = 0;
  localparam int FIRST_ROUTE_LSB = 5;
  localparam int SECOND_ROUTE_LSB = 2;
  localparam int READY_MODE_BIT = 1;
  localparam int RESERVED_BIT = 0;
  // ----------------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------------
  localparam logic [1:0] REF_INTERNAL = 2'h0;
  localparam logic [1:0] REF_DEDICATED = 2'h1;
  localparam logic [1:0] REF_SHARED = 2'h2;
  localparam logic [1:0] REF_SUPPLY = 2'h3;
  localparam logic [1:0] FILT_NONE = 2'h0;
  localparam logic [1:0] FILT_BOTH = 2'h1;
  localparam logic [1:0] FILT_50 = 2'h2;
  localparam logic [1:0] FILT_60 = 2'h3;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_DUTY = 2'h1;
  localparam logic [2:0] RATE_SLOWEST = 3'h0;
  // One-hot routing destinations: inputs 0..3, positive and negative dedicated reference.
  localparam int ROUTE_W = 6;
  localparam int CURRENT_W = 11;
  localparam logic [10:0] UA_OFF = 11'h000;
  localparam logic [10:0] UA_10 = 11'h00a;
  localparam logic [10:0] UA_50 = 11'h032;
  localparam logic [10:0] UA_100 = 11'h064;
  localparam logic [10:0] UA_250 = 11'h0fa;
  localparam logic [10:0] UA_500 = 11'h1f4;
  localparam logic [10:0] UA_1000 = 11'h3e8;
  localparam logic [10:0] UA_1500 = 11'h5dc;
  // Shared pin driver states.
  typedef enum logic [1:0] {
    PIN_IDLE = 2'b00,
    PIN_STATUS = 2'b01,
    PIN_DATA = 2'b10
  } acr_pin_e;
endpackage

// ---- core/acr_ready_if.sv ----
// Ready signalling between the register bank and the shared pin driver.
`timescale 1ns/1ns
`default_nettype none
interface acr_ready_if;
  logic ready_signal_mode;
  logic data_avail;
  logic shift_active;
  logic shift_bit;
  modport ctrl (output ready_signal_mode, output data_avail, output shift_active, output shift_bit);
  modport drv (input ready_signal_mode, input data_avail, input shift_active, input shift_bit);
endinterface
`default_nettype wire

// ---- tb/acr_config_regs_properties.sv ----
// Concurrent checks on the configuration register bank ports.
`timescale 1ns/1ns
`default_nettype none
module acr_config_regs_properties (
  input wire logic clk_i, input wire logic sys_rst_i,
  input wire logic [1:0] reg_addr_i, input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i, input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o, input wire logic reg_rdata_valid_o,
  input wire logic [1:0] op_mode_i, input wire logic [2:0] rate_code_i,
  input wire logic converting_i, input wire logic data_avail_i,
  input wire logic shift_active_i, input wire logic chip_select_n_i,
  input wire logic internal_ref_en_o, input wire logic dedicated_ref_en_o,
  input wire logic shared_ref_en_o, input wire logic supply_ref_en_o,
  input wire logic reject_50_o, input wire logic reject_60_o,
  input wire logic low_side_switch_enable_o, input wire logic [2:0] excitation_magnitude_o,
  input wire logic [10:0] excitation_current_ua_o, input wire logic [5:0] first_excitation_source_o,
  input wire logic [5:0] second_excitation_source_o, input wire logic shared_output_ready_pin_o,
  input wire logic shared_output_ready_pin_oe_o, input wire logic dedicated_ready_pin_n_o
);
  localparam logic [10:0] UA_TAB [8] = '{acr_pkg::UA_OFF, acr_pkg::UA_10, acr_pkg::UA_50, acr_pkg::UA_100,
    acr_pkg::UA_250, acr_pkg::UA_500, acr_pkg::UA_1000, acr_pkg::UA_1500};
  // ----
  // Shadow of the registers, in step with the bank itself; prev2 and prev3 lag one step behind.
  // ----
  logic [7:0] sh2, sh3, next_sh2, next_sh3, prev2, prev3, rd_exp;
  logic [1:0] filt_exp;
  logic sw_exp;
  always_comb begin
    next_sh2 = sh2;
    next_sh3 = sh3;
    if (reg_wr_i && reg_addr_i == acr_pkg::REF_FILT_EXC_OFS)
      next_sh2 = reg_wdata_i;
    if (reg_wr_i && reg_addr_i == acr_pkg::ROUTE_READY_OFS)
      next_sh3 = {reg_wdata_i[7:1], 1'b0};
    rd_exp = (reg_addr_i == 2'h2) ? sh2 : (reg_addr_i == 2'h3) ? sh3 : 8'h00;
    filt_exp = {sh2[5] ^ sh2[4], sh2[4]};
    if (rate_code_i != acr_pkg::RATE_SLOWEST || op_mode_i > acr_pkg::MODE_DUTY)
      filt_exp = 2'h0;
    sw_exp = sh2[3] & converting_i;
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sh2 <= 8'h00;
      sh3 <= 8'h00;
      prev2 <= 8'h00;
      prev3 <= 8'h00;
    end else begin
      sh2 <= next_sh2;
      sh3 <= next_sh3;
      prev2 <= sh2;
      prev3 <= sh3;
    end
  end
  function automatic logic [5:0] route(input logic [2:0] c);
    route = (c == 3'h0 || c == 3'h7) ? 6'h00 : 6'h01 << (c - 3'h1);
  endfunction
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_cs_release;
    $rose(chip_select_n_i) ##1 chip_select_n_i [*3];
  endsequence
  sequence s_status;
    ($fell(chip_select_n_i) && sh3[1]) ##1 (!chip_select_n_i && sh3[1] && !shift_active_i && $stable(data_avail_i)) [*5];
  endsequence
  property p_ref;
    {supply_ref_en_o, shared_ref_en_o, dedicated_ref_en_o, internal_ref_en_o} == 4'h1 << prev2[7:6];
  endproperty
  property p_filt;
    {reject_50_o, reject_60_o} == $past(filt_exp);
  endproperty
  property p_sw;
    low_side_switch_enable_o == $past(sw_exp);
  endproperty
  property p_mag;
    excitation_magnitude_o == prev2[2:0] && excitation_current_ua_o == UA_TAB[prev2[2:0]];
  endproperty
  property p_route;
    first_excitation_source_o == route(prev3[7:5]) && second_excitation_source_o == route(prev3[4:2]);
  endproperty
  property p_read;
    reg_rd_i |=> reg_rdata_valid_o && reg_rdata_o == $past(rd_exp);
  endproperty
  property p_no_read;
    !reg_rd_i |=> !reg_rdata_valid_o;
  endproperty
  property p_ready_pin;
    !$past(sys_rst_i) |-> dedicated_ready_pin_n_o == !$past(data_avail_i);
  endproperty
  property p_cs_release;
    s_cs_release |-> ##[0:1] !shared_output_ready_pin_oe_o;
  endproperty
  property p_status;
    s_status |-> shared_output_ready_pin_oe_o && shared_output_ready_pin_o == !data_avail_i;
  endproperty
  a_ref: assert property (p_ref) else $error("reference enables wrong");
  a_filt: assert property (p_filt) else $error("rejection outputs wrong");
  a_sw: assert property (p_sw) else $error("low side switch wrong");
  a_mag: assert property (p_mag) else $error("excitation magnitude wrong");
  a_route: assert property (p_route) else $error("excitation routing wrong");
  a_read: assert property (p_read) else $error("read answer wrong");
  a_no_read: assert property (p_no_read) else $error("read valid without read");
  a_ready_pin: assert property (p_ready_pin) else $error("ready pin wrong");
  a_cs_release: assert property (p_cs_release) else $error("shared pin not released");
  a_status: assert property (p_status) else $error("shared pin status wrong");
endmodule
bind acr_config_regs acr_config_regs_properties u_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .reg_rdata_valid_o(reg_rdata_valid_o), .op_mode_i(op_mode_i),
  .rate_code_i(rate_code_i), .converting_i(converting_i), .data_avail_i(data_avail_i),
  .shift_active_i(shift_active_i), .chip_select_n_i(chip_select_n_i), .internal_ref_en_o(internal_ref_en_o),
  .dedicated_ref_en_o(dedicated_ref_en_o), .shared_ref_en_o(shared_ref_en_o), .supply_ref_en_o(supply_ref_en_o),
  .reject_50_o(reject_50_o), .reject_60_o(reject_60_o), .low_side_switch_enable_o(low_side_switch_enable_o),
  .excitation_magnitude_o(excitation_magnitude_o), .excitation_current_ua_o(excitation_current_ua_o),
  .first_excitation_source_o(first_excitation_source_o), .second_excitation_source_o(second_excitation_source_o),
  .shared_output_ready_pin_o(shared_output_ready_pin_o), .shared_output_ready_pin_oe_o(shared_output_ready_pin_oe_o),
  .dedicated_ready_pin_n_o(dedicated_ready_pin_n_o));
`default_nettype wire

// ---- tb/acr_config_regs_tb_top.sv ----
// Self-checking bench for the configuration register bank.
`timescale 1ns/1ns
`default_nettype none
module acr_config_regs_tb_top;
  logic clk_i, sys_rst_i, conv, avail, sh_act, sh_bit, wr, rd, cs_n, line, valid;
  logic intr, ded, shr, sup, r50, r60, sw, pin, pin_oe, rdy_n;
  logic [1:0] addr, op_mode;
  logic [2:0] rate, mag;
  logic [7:0] wdata, rdata, d2, d3;
  logic [10:0] ua;
  logic [5:0] src1, src2;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int m2 = 0;
  int m3 = 0;
  int ua_tab [8] = '{0, 10, 50, 100, 250, 500, 1000, 1500};
  acr_host_model host (.clk_i(clk_i), .pin_i(pin), .pin_oe_i(pin_oe), .addr_o(addr), .wr_o(wr),
    .wdata_o(wdata), .rd_o(rd), .cs_n_o(cs_n), .line_o(line));
  acr_config_regs dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rdata_valid_o(valid),
    .op_mode_i(op_mode), .rate_code_i(rate), .converting_i(conv), .data_avail_i(avail),
    .shift_active_i(sh_act), .shift_bit_i(sh_bit), .chip_select_n_i(cs_n), .internal_ref_en_o(intr),
    .dedicated_ref_en_o(ded), .shared_ref_en_o(shr), .supply_ref_en_o(sup), .reject_50_o(r50),
    .reject_60_o(r60), .low_side_switch_enable_o(sw), .excitation_magnitude_o(mag),
    .excitation_current_ua_o(ua), .first_excitation_source_o(src1), .second_excitation_source_o(src2),
    .shared_output_ready_pin_o(pin), .shared_output_ready_pin_oe_o(pin_oe), .dedicated_ready_pin_n_o(rdy_n));
  task report_and_stop;
    if (errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  function automatic logic [5:0] rt(input logic [2:0] c);
    rt = (c == 3'h0 || c == 3'h7) ? 6'h00 : 6'h01 << (c - 3'h1);
  endfunction
  task rd_chk(input logic [1:0] a, input logic [7:0] e);
    host.acc(1'b0, 1'b1, a, 8'h00);
    chk("read_valid", 1'b1, valid);
    chk("read_data", e, rdata);
  endtask
  task check_outs;
    logic [1:0] f;
    f = m2[5:4];
    if (rate != 3'h0 || op_mode > 2'h1)
      f = 2'h0;
    chk("reference", 4'h1 << m2[7:6], {sup, shr, ded, intr});
    chk("filter", {f[0] ^ f[1], f[0]}, {r50, r60});
    chk("switch", m2[3] & conv, sw);
    chk("current", ua_tab[m2[2:0]], ua);
    chk("code", m2[2:0], mag);
    chk("first_route", rt(m3[7:5]), src1);
    chk("second_route", rt(m3[4:2]), src2);
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      report_and_stop;
    end
  end
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    sys_rst_i = 1'b1;
    {op_mode, rate, conv, avail, sh_act, sh_bit} = 9'h000;
    void'($urandom(39));
    repeat (4) @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    check_outs;
    rd_chk(2'h2, 8'h00);
    rd_chk(2'h3, 8'h00);
    // ----
    // Every code of the reference, filter, magnitude and routing fields, with random neighbours and levels.
    // ----
    for (int i = 0; i < 16; i++) begin
      d2 = 8'($urandom);
      d3 = 8'($urandom);
      d2[7:6] = i[1:0];
      d2[5:4] = i[3:2];
      d2[2:0] = i[2:0];
      d3[7:5] = i[2:0];
      d3[4:2] = ~i[2:0];
      op_mode = 2'($urandom_range(2));
      rate = i[0] ? 3'h0 : 3'($urandom);
      conv = 1'($urandom);
      host.acc(1'b1, 1'b0, 2'h2, d2);
      m2 = d2;
      host.acc(1'b1, 1'b1, 2'h3, d3);
      chk("old_value", m3, rdata);
      m3 = {d3[7:1], 1'b0};
      repeat (2) @(posedge clk_i);
      #1;
      check_outs;
      rd_chk(2'h2, m2);
      rd_chk(2'h3, m3);
    end
    for (int a = 0; a < 2; a++) begin
      host.acc(1'b1, 1'b0, 2'(a), 8'hff);
      rd_chk(2'(a), 8'h00);
    end
    rd_chk(2'h2, m2);
    // ----
    // A reset in mid-run brings every field back to its default.
    // ----
    sys_rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    m2 = 0;
    m3 = 0;
    check_outs;
    rd_chk(2'h2, 8'h00);
    rd_chk(2'h3, 8'h00);
    // ----
    // Ready on the shared pin in ready mode, plain data otherwise, released when deselected.
    // ----
    for (int v = 0; v < 4; v++) begin
      host.acc(1'b1, 1'b0, 2'h3, {6'h00, !v[1], 1'b0});
      avail = v[0];
      sh_bit = 1'($urandom);
      host.cs(1'b0);
      repeat (6) @(posedge clk_i);
      #1;
      chk("pin_enable", 1'b1, pin_oe);
      chk("pin_status", v[1] ? sh_bit : !v[0], line);
      chk("ready_pin", !v[0], rdy_n);
      sh_act = 1'b1;
      sh_bit = 1'($urandom);
      repeat (3) @(posedge clk_i);
      #1;
      chk("pin_data", sh_bit, line);
      sh_act = 1'b0;
      host.cs(1'b1);
      repeat (5) @(posedge clk_i);
      #1;
      chk("pin_released", 1'b0, pin_oe);
      chk("ready_kept", !v[0], rdy_n);
    end
    report_and_stop;
  end
endmodule
`default_nettype wire

// ---- tb/acr_host_model.sv ----
// Controller model: register strobes, chip select and its view of the shared pin.
`timescale 1ns/1ns
`default_nettype none
module acr_host_model (
  input wire logic clk_i,
  input wire logic pin_i,
  input wire logic pin_oe_i,
  output logic [1:0] addr_o,
  output logic wr_o,
  output logic [7:0] wdata_o,
  output logic rd_o,
  output logic cs_n_o,
  output logic line_o
);
  logic last = 1'b0;
  // A released line has no pull; show the inverse so a stale value never passes.
  assign line_o = pin_oe_i ? pin_i : ~last;
  always_ff @(posedge clk_i) begin
    if (pin_oe_i)
      last <= pin_i;
  end
  initial begin
    addr_o = 2'h0;
    wr_o = 1'b0;
    wdata_o = 8'h00;
    rd_o = 1'b0;
    cs_n_o = 1'b1;
  end
  task acc(input logic w, input logic r, input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wr_o = w;
    rd_o = r;
    wdata_o = (a == 2'h3) ? {d[7:1], 1'b0} : d;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    rd_o = 1'b0;
  endtask
  task cs(input logic v);
    @(posedge clk_i);
    #1;
    cs_n_o = v;
  endtask
endmodule
`default_nettype wire
